// file: verilog/ascs_regs.svh
// Constants of the serial conversion sequencer: codes, counts, reset values
`ifndef ASCS_REGS_SVH
`define ASCS_REGS_SVH

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define ASCS_CLK_PERIOD_NS 10
`define ASCS_DEBOUNCE_NS 50
`define ASCS_DEBOUNCE_CYC \
  ((`ASCS_DEBOUNCE_NS + `ASCS_CLK_PERIOD_NS - 1) / `ASCS_CLK_PERIOD_NS)
`define ASCS_CLEAR_CYC 4'h4
`define ASCS_CONV_CYC 40

// ---------------------------------------------------------------------
// Command nibble codes and link counts
// ---------------------------------------------------------------------
`define ASCS_CMD_PWRDN 4'hE
`define ASCS_CMD_RSVD 4'hF
`define ASCS_SAMPLE_FALL 5'h04
`define ASCS_CMD_BITS 4'h8
`define ASCS_LEN_RISE 4'h5
`define ASCS_LEN_8 5'h08
`define ASCS_LEN_12 5'h0C
`define ASCS_LEN_16 5'h10

// ---------------------------------------------------------------------
// Field positions of the configuration nibble and reset values
// ---------------------------------------------------------------------
`define ASCS_CFG_LEN_HI 3
`define ASCS_CFG_LEN_LO 2
`define ASCS_CFG_LSB_BIT 1
`define ASCS_CFG_BIP_BIT 0
`define ASCS_PD_RST 1'b1
`define ASCS_CS_RST 1'b1

`endif

// file: verilog/ascs_pkg.sv
// Types and shared decoders of the serial conversion sequencer
`include "ascs_regs.svh"

package ascs_pkg;

  // -------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b100
  } ascs_state_e;

  typedef struct packed {
    logic [7:0] cmd;
    logic [3:0] rise_cnt;
    logic [1:0] len;
  } ascs_rx_s;

  typedef struct packed {
    logic [4:0] fall_cnt;
    logic open;
    logic done;
    logic [3:0] nib;
  } ascs_tx_s;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic cs_lvl;
    logic [7:0] db_cnt;
    logic cs_db;
    logic [2:0] open_sync;
    logic open_lvl;
    logic [2:0] done_sync;
    logic done_lvl;
    ascs_state_e state;
    logic [15:0] conv_cnt;
    logic [3:0] clr_cnt;
    logic link_clear;
    logic pd;
    logic awake;
    logic [3:0] channel;
    logic [1:0] len;
    logic lsb_first;
    logic bipolar;
    logic [15:0] out_word;
  } ascs_sys_s;

  // -------------------------------------------------------------------
  // Decoders
  // -------------------------------------------------------------------
  // Output length field: 01 = 8, 11 = 16, x0 = 12 bits
  function automatic logic [4:0] ascs_len_bits(input logic [1:0] code);
    case (code)
      2'b01: ascs_len_bits = `ASCS_LEN_8;
      2'b11: ascs_len_bits = `ASCS_LEN_16;
      default: ascs_len_bits = `ASCS_LEN_12;
    endcase
  endfunction

  // Lays the result out in send order, bit 0 leaves first
  function automatic logic [15:0] ascs_arrange(input logic [11:0] res,
                                               input logic [1:0] len,
                                               input logic lsb,
                                               input logic bip);
    logic [11:0] val;
    logic [15:0] full;
    logic [15:0] lsw;
    logic [4:0] nbits;
    val = res;
    full = '0;
    lsw = '0;
    nbits = ascs_len_bits(len);
    // Bipolar code differs from unipolar in the inverted MSB
    val[11] = res[11] ^ bip;
    full = {val, 4'h0};
    case (nbits)
      `ASCS_LEN_8: lsw = {8'h00, val[11:4]};
      `ASCS_LEN_16: lsw = full;
      default: lsw = {4'h0, val};
    endcase
    for (int i = 0; i < 16; i++) begin
      // MSB-first order does not depend on the length read next time
      ascs_arrange[i] = lsb ? lsw[i] : full[15 - i];
    end
  endfunction

endpackage

// file: verilog/ascs_link_rx.sv
// Link receiver: shifts the command byte in on rising I/O clock edges
`timescale 1ns/10ps

module ascs_link_rx import ascs_pkg::*; (
  input wire logic io_clk,
  input wire logic link_clear,
  input wire logic command_serial_in,
  output logic [7:0] cmd_byte,
  output logic [1:0] len_code
);

  ascs_rx_s q;
  ascs_rx_s d;

  // -------------------------------------------------------------------
  // Shift register, stops after the eighth bit so the byte stays stable
  // -------------------------------------------------------------------
  always_comb begin
    d = q;
    if (q.rise_cnt != `ASCS_CMD_BITS) begin
      d.cmd = {q.cmd[6:0], command_serial_in}; // MSB first
      d.rise_cnt = 4'(q.rise_cnt + 4'h1);
      // Length field is known at the sixth edge, before the eighth fall
      if (q.rise_cnt == `ASCS_LEN_RISE) begin
        d.len = {q.cmd[0], command_serial_in};
      end
    end
  end

  // Clear is released long before the host clocks again
  always_ff @(posedge io_clk or posedge link_clear) begin
    if (link_clear) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cmd_byte = q.cmd;
  assign len_code = q.len;

endmodule // ascs_link_rx

// file: verilog/ascs_link_tx.sv
// Link transmitter side: counts falling I/O clock edges of a cycle
`timescale 1ns/10ps

module ascs_link_tx import ascs_pkg::*; (
  input wire logic io_clk,
  input wire logic link_clear,
  input wire logic [7:0] cmd_byte,
  input wire logic [1:0] len_code,
  output logic [4:0] bit_index,
  output logic sample_open,
  output logic length_done,
  output logic [3:0] cmd_nibble
);

  ascs_tx_s q;
  ascs_tx_s d;

  // -------------------------------------------------------------------
  // Falling edge counter with sticky phase flags
  // -------------------------------------------------------------------
  always_comb begin
    d = q;
    if (q.fall_cnt != `ASCS_LEN_16) begin
      d.fall_cnt = 5'(q.fall_cnt + 5'h01); // Next bit each fall
    end
    if (d.fall_cnt == `ASCS_SAMPLE_FALL && !q.open) begin
      d.open = 1'b1;
      d.nib = cmd_byte[3:0]; // Nibble frozen before bit five shifts in
    end
    if (d.fall_cnt == ascs_len_bits(len_code)) begin
      d.done = 1'b1;
    end
  end

  // Held clear while chip select is up, so no state moves
  always_ff @(negedge io_clk or posedge link_clear) begin
    if (link_clear) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bit_index = q.fall_cnt;
  assign sample_open = q.open;
  assign length_done = q.done;
  assign cmd_nibble = q.nib;

endmodule // ascs_link_tx

// file: verilog/ascs_sequencer.sv
// Conversion sequencer of a 12-bit serial converter, top level
`timescale 1ns/10ps

// Behaviour
// - End-of-conversion high in reset state
// - Sampling starts after fourth falling clock
// - Conversion starts after eighth, twelfth or sixteenth fall
// - End-of-conversion rises in the same edge that latches the result
// - Rising end-of-conversion returns to reset state
// - Select held low: first bit at rise
// - Select toggled: first bit at select fall
// - Next bit each falling clock up to the sixteenth
// - Serial output low while converting
// - Select high floats serial output at once
// - Debounced select high freezes the link
// - Debounced select low resets the sequencer
// - Early abort keeps previous result for next
// - Nibble 1110b enters power-down at fourth fall
// - Power-down: no conversion, result kept
// - Starts in power-down after reset
// - Valid channel command leaves power-down
// - Auto power-down after conversion, wake on select
// - Command byte MSB first, rising edges
// - Nibble selects channel, test, power-down
// - Length field decode, effective same cycle
module ascs_sequencer import ascs_pkg::*; #(
  parameter logic [15:0] CONV_CYCLES = 16'(`ASCS_CONV_CYC)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic io_clk,
  input wire logic cs_n,
  input wire logic command_serial_in,
  input wire logic [11:0] conv_result,
  output logic data_out,
  output logic data_out_oe,
  output logic eoc,
  output logic sampling,
  output logic [3:0] channel_sel,
  output logic analog_power,
  output logic power_down
);

  // -------------------------------------------------------------------
  // Constants
  // -------------------------------------------------------------------
  localparam logic [7:0] DEB_CYC = 8'(`ASCS_DEBOUNCE_CYC);

  localparam ascs_sys_s SYS_RST = '{
    cs_sync: {3{`ASCS_CS_RST}},
    cs_lvl: `ASCS_CS_RST,
    cs_db: `ASCS_CS_RST,
    state: ST_IDLE,
    link_clear: 1'b1,
    pd: `ASCS_PD_RST,
    default: '0
  };

  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  ascs_sys_s q;
  ascs_sys_s d;
  logic [7:0] cmd_byte;
  logic [1:0] len_code;
  logic [4:0] bit_index;
  logic sample_open;
  logic length_done;
  logic [3:0] cmd_nibble;
  logic open_rise;
  logic done_rise;
  logic cs_db_fall;
  logic cycle_start;

  // -------------------------------------------------------------------
  // Link side, clocked by the host's I/O clock
  // -------------------------------------------------------------------
  ascs_link_rx u_rx (
    .io_clk(io_clk),
    .link_clear(q.link_clear),
    .command_serial_in(command_serial_in),
    .cmd_byte(cmd_byte),
    .len_code(len_code)
  );

  ascs_link_tx u_tx (
    .io_clk(io_clk),
    .link_clear(q.link_clear),
    .cmd_byte(cmd_byte),
    .len_code(len_code),
    .bit_index(bit_index),
    .sample_open(sample_open),
    .length_done(length_done),
    .cmd_nibble(cmd_nibble)
  );

  // -------------------------------------------------------------------
  // Next state of the system-clock side
  // -------------------------------------------------------------------
  always_comb begin
    d = q;
    open_rise = 1'b0;
    done_rise = 1'b0;
    cs_db_fall = 1'b0;
    cycle_start = 1'b0;

    // Three-stage synchronisers, a change counts once stages 2 and 3 agree
    d.cs_sync = {q.cs_sync[1:0], cs_n};
    d.open_sync = {q.open_sync[1:0], sample_open};
    d.done_sync = {q.done_sync[1:0], length_done};
    if (q.cs_sync[2] == q.cs_sync[1]) begin
      d.cs_lvl = q.cs_sync[2];
    end
    if (q.open_sync[2] == q.open_sync[1]) begin
      d.open_lvl = q.open_sync[2];
    end
    if (q.done_sync[2] == q.done_sync[1]) begin
      d.done_lvl = q.done_sync[2];
    end
    // Flags are stable levels, so rising edges are single events
    open_rise = d.open_lvl & ~q.open_lvl;
    done_rise = d.done_lvl & ~q.done_lvl;

    // Chip select debounce: the new level must persist DEB_CYC cycles
    if (q.cs_lvl == q.cs_db) begin
      d.db_cnt = '0;
    end else if (q.db_cnt >= DEB_CYC - 8'h01) begin
      d.db_cnt = '0;
      d.cs_db = q.cs_lvl;
    end else begin
      d.db_cnt = 8'(q.db_cnt + 8'h01);
    end
    cs_db_fall = q.cs_db & ~d.cs_db;

    // Sequencer
    case (q.state)
      ST_IDLE: begin
        if (open_rise && !q.cs_db) begin
          if (cmd_nibble == `ASCS_CMD_PWRDN) begin
            d.pd = 1'b1; // No sampling in this cycle
          end else if (cmd_nibble == `ASCS_CMD_RSVD && q.pd) begin
            d.pd = 1'b1; // Reserved code cannot wake the core
          end else begin
            d.pd = 1'b0;
            d.state = ST_SAMPLE;
            d.awake = 1'b1;
            // Reserved code keeps the previous input selected
            if (cmd_nibble != `ASCS_CMD_RSVD) begin
              d.channel = cmd_nibble;
            end
          end
        end
      end
      ST_SAMPLE: begin
        if (done_rise) begin
          d.state = ST_CONVERT; // Switch opens, EOC falls
          d.conv_cnt = 16'(CONV_CYCLES - 16'h0001);
          // Format bits belong to the conversion now starting
          if (cmd_nibble != `ASCS_CMD_RSVD) begin
            d.len = cmd_byte[`ASCS_CFG_LEN_HI:`ASCS_CFG_LEN_LO];
            d.lsb_first = cmd_byte[`ASCS_CFG_LSB_BIT];
            d.bipolar = cmd_byte[`ASCS_CFG_BIP_BIT];
          end
        end
      end
      ST_CONVERT: begin
        if (q.conv_cnt == 16'h0000) begin
          // Result is latched in the same edge that raises EOC
          d.out_word = ascs_arrange(conv_result, q.len, q.lsb_first,
                                    q.bipolar);
          d.state = ST_IDLE;
          d.awake = 1'b0; // Auto power-down right away
          cycle_start = 1'b1;
        end else begin
          d.conv_cnt = 16'(q.conv_cnt - 16'h0001);
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase

    // Debounced select low aborts any cycle; result buffer is untouched
    if (cs_db_fall) begin
      d.state = ST_IDLE;
      d.awake = 1'b1; // Core resumes shortly after select
      cycle_start = 1'b1;
    end

    // Link clear: held while deselected, pulsed at each cycle start.
    // Async clear of the link is safe only because the host keeps the
    // I/O clock low for a while after a cycle start.
    if (cycle_start) begin
      d.clr_cnt = `ASCS_CLEAR_CYC;
    end else if (q.clr_cnt != 4'h0) begin
      d.clr_cnt = 4'(q.clr_cnt - 4'h1);
    end
    d.link_clear = d.cs_db | (d.clr_cnt != 4'h0);
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= SYS_RST; // Power-down after reset
    end else begin
      q <= d;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  // EOC stays high outside conversion, also while sampling
  assign eoc = (q.state != ST_CONVERT);
  assign sampling = (q.state == ST_SAMPLE);
  assign channel_sel = q.channel;
  // Core runs only when awake and not in software power-down
  assign analog_power = q.awake & ~q.pd;
  assign power_down = q.pd;

  // Driver follows the select pin with no delay, freeing the line
  assign data_out_oe = ~cs_n;

  // Index is zero whenever a cycle starts, so bit 0 shows at EOC rise
  // or at select fall; converting forces the line low.
  always_comb begin
    if (q.state == ST_CONVERT) begin
      data_out = 1'b0;
    end else if (bit_index[4]) begin
      data_out = 1'b0;
    end else begin
      data_out = q.out_word[bit_index[3:0]];
    end
  end

endmodule // ascs_sequencer

// file: verif/ascs_sequencer_props.sv
// Concurrent checks on the pins of the conversion sequencer
`timescale 1ns/10ps

module ascs_sequencer_props import ascs_pkg::*; #(
  parameter logic [15:0] CONV_CYCLES = 16'h0028
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic io_clk,
  input wire logic cs_n,
  input wire logic command_serial_in,
  input wire logic [11:0] conv_result,
  input wire logic data_out,
  input wire logic data_out_oe,
  input wire logic eoc,
  input wire logic sampling,
  input wire logic [3:0] channel_sel,
  input wire logic analog_power,
  input wire logic power_down
);
  // ---------------------------------------------------------------
  // Helper logic and sequences
  // ---------------------------------------------------------------
  logic [15:0] low_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Length of the low phase; cleared while idle so aborts cannot leak
  always_ff @(posedge clk_sys) begin
    if (!reset_n || eoc) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= low_q + 16'h0001;
    end
  end

  sequence conv_start_s;
    $fell(eoc);
  endsequence

  sequence conv_end_s;
    $rose(eoc);
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  reset_state_a: assert property ($rose(reset_n) |->
    eoc && power_down && !sampling) else $error("bad state after reset");
  sample_high_a: assert property (sampling |-> eoc)
    else $error("sampling while end of conversion low");
  switch_open_a: assert property (conv_start_s |-> !sampling)
    else $error("switch still closed at conversion start");
  conv_len_a: assert property (conv_end_s |->
    low_q >= CONV_CYCLES - 16'h0001 && low_q <= CONV_CYCLES + 16'h0001)
    else $error("conversion length off");
  back_idle_a: assert property (conv_end_s |=>
    (eoc && !sampling) [*8]) else $error("no return to idle");
  serial_low_a: assert property (!eoc |-> !data_out)
    else $error("serial output high while converting");
  float_sel_a: assert property (cs_n |-> !data_out_oe)
    else $error("serial output driven while deselected");
  pd_hold_a: assert property (power_down |-> eoc)
    else $error("conversion during power down");
  power_conv_a: assert property (!eoc |-> analog_power)
    else $error("converting without analog power");
  auto_off_a: assert property (conv_end_s |-> ##[0:2] !analog_power)
    else $error("analog power kept after conversion");
endmodule // ascs_sequencer_props

bind ascs_sequencer ascs_sequencer_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .io_clk(io_clk), .cs_n(cs_n),
  .command_serial_in(command_serial_in), .conv_result(conv_result),
  .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc),
  .sampling(sampling), .channel_sel(channel_sel),
  .analog_power(analog_power), .power_down(power_down));

// file: verif/ascs_host_model.sv
// Host serial port model: select, shift clock and command line
`timescale 1ns/10ps

module ascs_host_model (
  input wire logic clk_sys,
  input wire logic data_out,
  output logic io_clk,
  output logic cs_n,
  output logic command_serial_in
);
  // Clock rests low outside frames; select starts released
  initial begin
    io_clk = 1'b0;
    cs_n = 1'b1;
    command_serial_in = 1'b0;
  end

  // Select change off the system edge, then the settle the device needs
  task automatic select(input logic lo);
    @(posedge clk_sys);
    #1;
    cs_n = !lo;
    #(lo ? 200 : 100);
  endtask

  // Frame of n clocks at 12 ns; a result bit is read on each rise
  task automatic frame(input logic [7:0] cmd, input int n,
                       output logic [15:0] got);
    got = 16'h0000;
    for (int k = 0; k < n; k++) begin
      // Past the byte the line toggles so stale levels never look valid
      command_serial_in = (k < 8) ? cmd[7-k] : !command_serial_in;
      #6;
      io_clk = 1'b1;
      got[k] = data_out;
      #6;
      io_clk = 1'b0;
    end
    command_serial_in = !command_serial_in;
  endtask
endmodule // ascs_host_model

// file: verif/ascs_sequencer_tb_top.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/10ps
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value at %0t: got %h expected %h", \
  $time, g, e); end end

module ascs_sequencer_tb_top import ascs_pkg::*;;
  logic clk_sys, reset_n, io_clk, cs_n, command_serial_in;
  logic data_out, data_out_oe, eoc, sampling, analog_power, power_down;
  logic [11:0] conv_result;
  logic [3:0] channel_sel;
  logic [15:0] exp_w;
  logic [15:0] junk;
  logic pd_exp;
  int err_count, comparisons, cyc, seed, exp_n;

  // Short conversion keeps the run brief; checks derive from it
  ascs_sequencer #(.CONV_CYCLES(16'h0008)) u_dut (.clk_sys(clk_sys),
    .reset_n(reset_n), .io_clk(io_clk), .cs_n(cs_n),
    .command_serial_in(command_serial_in), .conv_result(conv_result),
    .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc),
    .sampling(sampling), .channel_sel(channel_sel),
    .analog_power(analog_power), .power_down(power_down));

  ascs_host_model u_host (.clk_sys(clk_sys), .data_out(data_out),
    .io_clk(io_clk), .cs_n(cs_n), .command_serial_in(command_serial_in));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = !clk_sys;
  end

  // ---------------------------------------------------------------
  // Expectations
  // ---------------------------------------------------------------
  function automatic int nbits(input logic [1:0] len);
    return (len == 2'b01) ? 8 : (len == 2'b11) ? 16 : 12;
  endfunction

  // Bit k of the result is the k-th bit on the wire
  function automatic logic [15:0] exp_word(input logic [11:0] r,
                                           input logic [7:0] cmd);
    logic [11:0] v;
    logic [15:0] f;
    int n;
    v = r;
    v[11] = r[11] ^ cmd[0];
    f = {v, 4'h0};
    n = nbits(cmd[3:2]);
    for (int k = 0; k < 16; k++) begin
      exp_word[k] = (k >= n) ? 1'b0 : !cmd[1] ? f[15-k] :
        (n == 16) ? f[k] : (n == 8) ? v[4+k] : v[k];
    end
  endfunction

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic wait_eoc(input logic lvl);
    for (int i = 0; i < 80 && eoc !== lvl; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHECK(eoc, lvl)
  endtask

  // One I/O cycle; only bits valid under both lengths are compared
  task automatic run(input logic [7:0] cmd, input logic tog);
    logic [15:0] got;
    logic [15:0] m;
    int n;
    n = nbits(cmd[3:2]);
    m = 16'hFFFF >> (16 - ((n < exp_n) ? n : exp_n));
    @(posedge clk_sys);
    #1;
    conv_result = 12'($random(seed));
    if (tog) begin
      u_host.select(1'b0);
      #1;
      `CHECK(data_out_oe, 1'b0)
      u_host.select(1'b1);
    end
    u_host.frame(cmd, n, got);
    `CHECK(got & m, exp_w & m)
    if (cmd[7:4] == 4'hE || (pd_exp && cmd[7:4] == 4'hF)) begin
      pd_exp = 1'b1;
      repeat (30) @(posedge clk_sys);
      #1;
      `CHECK({eoc, power_down}, 2'b11)
    end else begin
      wait_eoc(1'b0);
      wait_eoc(1'b1);
      pd_exp = 1'b0;
      exp_w = exp_word(conv_result, cmd);
      exp_n = n;
      `CHECK({power_down, channel_sel}, {1'b0, cmd[7:4]})
      repeat (12) @(posedge clk_sys);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h7b3b23e8;
    reset_n = 1'b0;
    conv_result = 12'h000;
    exp_w = 16'h0000;
    exp_n = 12;
    pd_exp = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    @(posedge clk_sys);
    #1;
    `CHECK({eoc, sampling, power_down}, 3'b101)
    u_host.select(1'b1);
    run(8'h0C, 1'b0);
    run(8'hE0, 1'b0);
    run(8'hF0, 1'b1);
    run(8'h93, 1'b1);
    // Every length code, test inputs and channel 10 among them
    for (int l = 0; l < 4; l++) begin
      run({l[3:0] + 4'hA, l[1:0], l[0], l[1]}, l[0]);
    end
    // Abort in mid transfer: the old result must come out again
    u_host.select(1'b0);
    u_host.select(1'b1);
    u_host.frame(8'($random(seed)), 5, junk);
    run(8'h21, 1'b1);
    for (int i = 0; i < 16; i++) begin
      run({4'({$random(seed)} % 14), 4'($random(seed))},
          1'($random(seed)));
    end
    complete_run;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_sys);
      cyc++;
      if (cyc == 20000) begin
        err_count++;
        complete_run;
      end
    end
  end
endmodule // ascs_sequencer_tb_top
